/* rtl/gsmb_bridge.sv */
/*
 * Serial master bridge: a host serial port loads, runs and reads back a
 * six-byte holding store that drives an I2C or SPI master on three
 * open-drain auxiliary pins, paced entirely by the host serial clock.
 * Assumes external pull-ups on the pins, a neighbouring unit that checks
 * the load frame's check code and supplies the read frame's check code.
 */
`timescale 1ns/1ps
`default_nettype none
module gsmb_bridge #(
   parameter int unsigned WDOG_CYCLES = gsmb_pkg::WDOG_CYCLES  // Idle time to pin reset
) (
   input wire logic i_clk,                     // 100 MHz system clock
   input wire logic i_arst_n,                  // Asynchronous reset, low active
   input wire logic i_host_chip_select_n,      // Host frame select, low active
   input wire logic i_host_sck,                // Host serial clock
   input wire logic i_host_sdi,                // Host serial data in
   output logic o_host_sdo,                    // Host serial data out
   input wire logic i_data_check_ok,           // Load check code matched
   input wire logic [15:0] i_read_check_code,  // Check code for read frame
   input wire logic [2:0] i_aux_out_bits,      // Pin output bits 5..3, 1 = release
   input wire logic i_aux_pin_3,               // Pin 3 level
   output logic o_aux_pin_3,                   // Pin 3 driven value
   output logic o_aux_pin_3_oe,                // Pin 3 pull-low enable
   input wire logic i_aux_pin_4,               // Pin 4 level
   output logic o_aux_pin_4,                   // Pin 4 driven value
   output logic o_aux_pin_4_oe,                // Pin 4 pull-low enable
   input wire logic i_aux_pin_5,               // Pin 5 level
   output logic o_aux_pin_5,                   // Pin 5 driven value
   output logic o_aux_pin_5_oe                 // Pin 5 pull-low enable
);
   // Fetch one 16-bit slot of the store
   function automatic logic [15:0] slot_of(input logic [47:0] s, input logic [1:0] idx);
      unique case (idx)
         2'h0: slot_of = s[47:32];
         2'h1: slot_of = s[31:16];
         default: slot_of = s[15:0];
      endcase
   endfunction

   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [5:0] pins_s;
   logic csb_s, sck_s, sdi_s, pin3_s, pin4_s, pin5_s;
   logic sck_prev_q, csb_prev_q;
   logic sck_rise, sck_fall, csb_rise, csb_fall;
   logic [6:0] bit_cnt_q;
   logic [15:0] cmd_q;
   logic [47:0] shadow_q, store_q;
   logic [31:0] wd_cnt_q;
   logic wd_expire;
   logic load_done, load_full;
   logic run_on, step_ev;
   logic [5:0] step_q;
   logic [1:0] byte_q;
   logic [15:0] slot_now;
   logic [3:0] pre_q, post_q, pre_rb_q, post_rb_q;
   logic [7:0] dat_q, txd_q, rxd_q;
   logic skip_q;
   logic [2:0] lvl_q, oe_q;
   logic zero_q;
   logic in_bits;
   logic [5:0] bofs;
   logic [1:0] ph;
   logic [63:0] read_word;
   logic [5:0] rd_idx;
   logic sdo_q;

   // Reset release through two flops
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // All pin and host inputs come from other clocks
   gsmb_sync #(.WIDTH(6)) u_sync (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_d({i_host_chip_select_n, i_host_sck, i_host_sdi, i_aux_pin_3, i_aux_pin_4, i_aux_pin_5}),
      .o_q(pins_s)
   );
   assign {csb_s, sck_s, sdi_s, pin3_s, pin4_s, pin5_s} = pins_s;

   // Edge history of host clock and select
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_prev_q <= 1'b1;
         csb_prev_q <= 1'b1;
      end else begin
         sck_prev_q <= sck_s;
         csb_prev_q <= csb_s;
      end
   end
   assign sck_rise = sck_s & ~sck_prev_q & ~csb_s;
   assign sck_fall = ~sck_s & sck_prev_q & ~csb_s;
   assign csb_rise = csb_s & ~csb_prev_q;
   assign csb_fall = ~csb_s & csb_prev_q;

   // Host frame: bit count, command word, load shadow
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_q <= 7'h0;
         cmd_q <= gsmb_pkg::CMD_NONE;
      end else if (csb_fall) begin
         bit_cnt_q <= 7'h0;
         cmd_q <= gsmb_pkg::CMD_NONE;
      end else if (sck_rise) begin
         if (bit_cnt_q != gsmb_pkg::BIT_CNT_MAX) begin
            bit_cnt_q <= bit_cnt_q + 7'h1;
         end
         if (bit_cnt_q < gsmb_pkg::CMD_BITS) begin
            cmd_q <= {cmd_q[14:0], sdi_s};
         end
      end
   end

   // Six load bytes shift in, most significant first
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         shadow_q <= gsmb_pkg::STORE_RESET;
      end else if (sck_rise && cmd_q == gsmb_pkg::CMD_LOAD_HOLDING &&
                   bit_cnt_q >= gsmb_pkg::HDR_BITS && bit_cnt_q < gsmb_pkg::DATA_END) begin
         shadow_q <= {shadow_q[46:0], sdi_s};
      end
   end

   // Load ends at select rise; a short frame counts as a failed check
   assign load_done = csb_rise && cmd_q == gsmb_pkg::CMD_LOAD_HOLDING && bit_cnt_q >= gsmb_pkg::HDR_BITS;
   assign load_full = bit_cnt_q >= gsmb_pkg::FRAME_END;

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         wd_cnt_q <= 32'h0;
      end else if (csb_fall) begin
         wd_cnt_q <= 32'h0;
      end else if (wd_cnt_q != WDOG_CYCLES) begin
         wd_cnt_q <= wd_cnt_q + 32'h1;
      end
   end
   assign wd_expire = wd_cnt_q == 32'(WDOG_CYCLES - 1);

   // Steps run on host clock edges after the command header
   assign run_on = cmd_q == gsmb_pkg::CMD_RUN_TRANSFER && bit_cnt_q >= gsmb_pkg::HDR_BITS &&
                   byte_q != gsmb_pkg::SLOT_COUNT;
   // One step per host edge, so each step spans half a host clock
   assign step_ev = run_on & (sck_rise | sck_fall);

   // Step and byte counters of the run frame
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         step_q <= gsmb_pkg::ST_P0;
         byte_q <= 2'h0;
      end else if (csb_fall) begin
         step_q <= gsmb_pkg::ST_P0;
         byte_q <= 2'h0;
      end else if (step_ev) begin
         if (step_q == gsmb_pkg::ST_LAST) begin
            step_q <= gsmb_pkg::ST_P0;
            byte_q <= byte_q + 2'h1;
         end else begin
            step_q <= step_q + 6'h1;
         end
      end
   end

   // Slot fields; latched at step 0 since readback rewrites them
   assign slot_now = slot_of(store_q, byte_q);
   assign in_bits = step_q >= gsmb_pkg::ST_BIT0 && step_q < gsmb_pkg::ST_ACK_LOW;
   assign bofs = step_q - gsmb_pkg::ST_BIT0;
   assign ph = bofs[1:0];

   // Master sequencer: pin levels (1 = released), shifters, readback
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         lvl_q <= 3'h7;
         pre_q <= gsmb_pkg::PRE_I2C_NOTX;
         post_q <= gsmb_pkg::POST_I2C_MACK;
         dat_q <= 8'hff;
         txd_q <= 8'hff;
         rxd_q <= 8'hff;
         skip_q <= 1'b1;
         pre_rb_q <= gsmb_pkg::RB_BLANK_HIGH;
         post_rb_q <= gsmb_pkg::RB_MASTER_ACK;
      end else if (wd_expire) begin
         // Expiry returns pins to released defaults
         lvl_q <= 3'h7;
         skip_q <= 1'b1;
      end else if (step_ev && step_q == gsmb_pkg::ST_P0) begin
         pre_q <= slot_now[15:12];
         dat_q <= slot_now[11:4];
         txd_q <= slot_now[11:4];
         post_q <= slot_now[3:0];
         skip_q <= 1'b0;
         // Top pre bit picks the bus
         if (slot_now[15]) begin
            pre_rb_q <= gsmb_pkg::RB_SPI_PRE;
            post_rb_q <= gsmb_pkg::RB_SPI_POST;
            unique case (slot_now[15:12])
               // Select low, or high ahead of the falling edge
               gsmb_pkg::PRE_SPI_CS_LOW: lvl_q <= 3'b110;
               gsmb_pkg::PRE_SPI_CS_EDGE: lvl_q <= 3'b111;
               default: begin
                  // Select high or no transmit releases all
                  lvl_q <= 3'h7;
                  skip_q <= 1'b1;
               end
            endcase
         end else begin
            pre_rb_q <= slot_now[15:12];
            post_rb_q <= slot_now[3:0];
            unique case (slot_now[15:12])
               // Start: data high first, clock follows
               gsmb_pkg::PRE_I2C_START: lvl_q[1] <= 1'b1;
               gsmb_pkg::PRE_I2C_STOP: lvl_q[2] <= 1'b0;
               // Blank reads back the idle data level
               gsmb_pkg::PRE_I2C_BLANK: pre_rb_q <= pin4_s ? gsmb_pkg::RB_BLANK_HIGH : gsmb_pkg::RB_BLANK_LOW;
               default: begin
                  lvl_q[2:1] <= 2'h3;
                  skip_q <= 1'b1;
               end
            endcase
         end
      end else if (step_ev && !skip_q) begin
         if (pre_q[3]) begin
            // Mode 3: data set on falling, slave samples on rising
            if (step_q == gsmb_pkg::ST_P2 && pre_q == gsmb_pkg::PRE_SPI_CS_EDGE) begin
               lvl_q[0] <= 1'b0;
            end else if (in_bits && ph == gsmb_pkg::PH_LOW) begin
               lvl_q[2:1] <= {1'b0, txd_q[7]};
               txd_q <= {txd_q[6:0], 1'b1};
            end else if (in_bits && ph == gsmb_pkg::PH_HIGH) begin
               lvl_q[2] <= 1'b1;
            end else if (in_bits && ph == gsmb_pkg::PH_SAMPLE) begin
               rxd_q <= {rxd_q[6:0], pin4_s};
            end else if (step_q == gsmb_pkg::ST_LAST && post_q == gsmb_pkg::POST_SPI_CS_HIGH) begin
               // Select rises at byte end, else stays low
               lvl_q[0] <= 1'b1;
            end
         end else begin
            unique case (step_q)
               gsmb_pkg::ST_P1: begin
                  if (pre_q == gsmb_pkg::PRE_I2C_START) begin
                     lvl_q[2] <= 1'b1;
                  end else if (pre_q == gsmb_pkg::PRE_I2C_STOP) begin
                     lvl_q[1] <= 1'b0;
                  end
               end
               gsmb_pkg::ST_P2: begin
                  // Data falls under high clock: start
                  if (pre_q == gsmb_pkg::PRE_I2C_START) begin
                     lvl_q[1] <= 1'b0;
                  end else if (pre_q == gsmb_pkg::PRE_I2C_STOP) begin
                     lvl_q[2] <= 1'b1;
                  end
               end
               gsmb_pkg::ST_P4: begin
                  if (pre_q == gsmb_pkg::PRE_I2C_START) begin
                     lvl_q[2] <= 1'b0;
                  end else if (pre_q == gsmb_pkg::PRE_I2C_STOP) begin
                     // Data rises: stop, lines stay high, rest skipped
                     lvl_q[1] <= 1'b1;
                     skip_q <= 1'b1;
                  end
               end
               gsmb_pkg::ST_ACK_LOW: lvl_q[2] <= 1'b0;
               // Ninth clock: master ACK pulls data low
               gsmb_pkg::ST_ACK_DRV: lvl_q[1] <= post_q != gsmb_pkg::POST_I2C_MACK;
               gsmb_pkg::ST_ACK_HIGH: lvl_q[2] <= 1'b1;
               gsmb_pkg::ST_ACK_SAMP: begin
                  if (post_q == gsmb_pkg::POST_I2C_MACK) begin
                     post_rb_q <= gsmb_pkg::RB_MASTER_ACK;
                  end else if (post_q == gsmb_pkg::POST_I2C_MNACK_STOP) begin
                     post_rb_q <= pin4_s ? gsmb_pkg::RB_NACK_STOP : gsmb_pkg::RB_ACK_STOP;
                  end else begin
                     post_rb_q <= pin4_s ? gsmb_pkg::RB_SLAVE_NACK : gsmb_pkg::RB_SLAVE_ACK;
                  end
               end
               gsmb_pkg::ST_END_LOW: lvl_q[2] <= 1'b0;
               // NACK plus stop: data low, clock high, data high
               gsmb_pkg::ST_STOP_SDA: begin
                  if (post_q == gsmb_pkg::POST_I2C_MNACK_STOP) begin
                     lvl_q[1] <= 1'b0;
                  end
               end
               gsmb_pkg::ST_STOP_SCL: begin
                  if (post_q == gsmb_pkg::POST_I2C_MNACK_STOP) begin
                     lvl_q[2] <= 1'b1;
                  end
               end
               gsmb_pkg::ST_STOP_END: begin
                  if (post_q == gsmb_pkg::POST_I2C_MNACK_STOP) begin
                     lvl_q[1] <= 1'b1;
                  end
               end
               default: begin
                  if (in_bits && ph == gsmb_pkg::PH_LOW) begin
                     lvl_q[2] <= 1'b0;
                  end else if (in_bits && ph == gsmb_pkg::PH_DRIVE) begin
                     lvl_q[1] <= txd_q[7];
                     txd_q <= {txd_q[6:0], 1'b1};
                  end else if (in_bits && ph == gsmb_pkg::PH_HIGH) begin
                     lvl_q[2] <= 1'b1;
                  end else if (in_bits && ph == gsmb_pkg::PH_SAMPLE) begin
                     rxd_q <= {rxd_q[6:0], pin4_s};
                  end
               end
            endcase
         end
      end
   end

   // Holding store: load, watchdog, and per-byte readback
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         store_q <= gsmb_pkg::STORE_RESET;
      end else if (wd_expire) begin
         store_q <= gsmb_pkg::STORE_RESET;
      end else if (load_done) begin
         // Failed or short load fills the store with ones
         store_q <= (load_full && i_data_check_ok) ? shadow_q : gsmb_pkg::STORE_FAIL;
      end else if (step_ev && step_q == gsmb_pkg::ST_LAST) begin
         // Received byte replaces the sent one unless the slot was skipped
         for (int b = 0; b < gsmb_pkg::SLOTS; b++) begin
            if (byte_q == 2'(b)) begin
               store_q[gsmb_pkg::SLOT_W*(gsmb_pkg::SLOTS-b)-1 -: gsmb_pkg::SLOT_W] <=
                  {pre_rb_q, skip_q ? dat_q : rxd_q, post_rb_q};
            end
         end
      end
   end

   // Read frame: six store bytes, then the check code
   assign read_word = {store_q, i_read_check_code};
   assign rd_idx = gsmb_pkg::RD_LAST_IDX - 6'(bit_cnt_q - gsmb_pkg::HDR_BITS);
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         sdo_q <= 1'b1;
      end else if (csb_s) begin
         sdo_q <= 1'b1;
      end else if (sck_fall) begin
         if (cmd_q == gsmb_pkg::CMD_READ_HOLDING && bit_cnt_q >= gsmb_pkg::HDR_BITS &&
             bit_cnt_q < gsmb_pkg::FRAME_END) begin
            sdo_q <= read_word[rd_idx];
         end else begin
            sdo_q <= 1'b1;
         end
      end
   end
   assign o_host_sdo = sdo_q;

   // Pins pull low when master or output bit asks; open drain only
   // A cleared output bit holds the pin low over the master
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_pin
         always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
               oe_q[g] <= 1'b0;
            end else begin
               oe_q[g] <= ~(lvl_q[g] & i_aux_out_bits[g]);
            end
         end
      end
   endgenerate

   // Driven value is always low; the pull-up gives the high
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         zero_q <= 1'b0;
      end else begin
         zero_q <= 1'b0;
      end
   end
   assign o_aux_pin_3 = zero_q;
   assign o_aux_pin_4 = zero_q;
   assign o_aux_pin_5 = zero_q;
   assign o_aux_pin_3_oe = oe_q[0];
   assign o_aux_pin_4_oe = oe_q[1];
   assign o_aux_pin_5_oe = oe_q[2];

   // Pin readback inputs beyond the data line are unused by the master
   logic unused_pins;
   assign unused_pins = pin3_s ^ pin5_s;
endmodule
`default_nettype wire

/* rtl/gsmb_pkg.sv */
/*
 * Shared constants of the pin-level serial master bridge: host command
 * codes, frame bit positions, action codes, readback codes and timing.
 * Assumes a single 100 MHz system clock drives the design.
 */
package gsmb_pkg;
   // System clock and watchdog time
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned WDOG_TIME_MS = 2000;
   localparam int unsigned WDOG_CYCLES = WDOG_TIME_MS * (CLK_HZ / 1000);

   // Host command words; the values are arbitrary
   localparam logic [15:0] CMD_LOAD_HOLDING = 16'h0001;
   localparam logic [15:0] CMD_RUN_TRANSFER = 16'h0002;
   localparam logic [15:0] CMD_READ_HOLDING = 16'h0003;
   localparam logic [15:0] CMD_NONE = 16'h0000;

   // Host frame bit positions, counted in host clock rising edges
   localparam logic [6:0] CMD_BITS = 7'h10;
   localparam logic [6:0] HDR_BITS = 7'h20;
   localparam logic [6:0] DATA_END = 7'h50;
   localparam logic [6:0] FRAME_END = 7'h60;
   localparam logic [6:0] BIT_CNT_MAX = 7'h7f;
   localparam logic [5:0] RD_LAST_IDX = 6'h3f;

   // Holding store layout and values
   localparam int unsigned SLOTS = 3;
   localparam int unsigned SLOT_W = 16;
   localparam logic [1:0] SLOT_COUNT = 2'h3;
   localparam logic [47:0] STORE_RESET = 48'hffffffffffff;
   localparam logic [47:0] STORE_FAIL = 48'hffffffffffff;

   // Steps of one byte slot, two per host clock
   localparam logic [5:0] ST_P0 = 6'h00;
   localparam logic [5:0] ST_P1 = 6'h01;
   localparam logic [5:0] ST_P2 = 6'h02;
   localparam logic [5:0] ST_P4 = 6'h04;
   localparam logic [5:0] ST_BIT0 = 6'h06;
   localparam logic [5:0] ST_ACK_LOW = 6'h26;
   localparam logic [5:0] ST_ACK_DRV = 6'h27;
   localparam logic [5:0] ST_ACK_HIGH = 6'h28;
   localparam logic [5:0] ST_ACK_SAMP = 6'h29;
   localparam logic [5:0] ST_END_LOW = 6'h2a;
   localparam logic [5:0] ST_STOP_SDA = 6'h2b;
   localparam logic [5:0] ST_STOP_SCL = 6'h2c;
   localparam logic [5:0] ST_STOP_END = 6'h2e;
   localparam logic [5:0] ST_LAST = 6'h2f;
   localparam logic [1:0] PH_LOW = 2'h0;
   localparam logic [1:0] PH_DRIVE = 2'h1;
   localparam logic [1:0] PH_HIGH = 2'h2;
   localparam logic [1:0] PH_SAMPLE = 2'h3;

   // Pre-action and post-action write codes
   localparam logic [3:0] PRE_I2C_START = 4'h6;
   localparam logic [3:0] PRE_I2C_STOP = 4'h1;
   localparam logic [3:0] PRE_I2C_BLANK = 4'h0;
   localparam logic [3:0] PRE_I2C_NOTX = 4'h7;
   localparam logic [3:0] POST_I2C_MACK = 4'h0;
   localparam logic [3:0] POST_I2C_MNACK = 4'h8;
   localparam logic [3:0] POST_I2C_MNACK_STOP = 4'h9;
   localparam logic [3:0] PRE_SPI_CS_LOW = 4'h8;
   localparam logic [3:0] PRE_SPI_CS_EDGE = 4'ha;
   localparam logic [3:0] PRE_SPI_CS_HIGH = 4'h9;
   localparam logic [3:0] PRE_SPI_NOTX = 4'hf;
   localparam logic [3:0] POST_SPI_CS_HIGH = 4'h9;

   // Readback codes
   localparam logic [3:0] RB_BLANK_LOW = 4'h0;
   localparam logic [3:0] RB_BLANK_HIGH = 4'h7;
   localparam logic [3:0] RB_MASTER_ACK = 4'h0;
   localparam logic [3:0] RB_SLAVE_ACK = 4'h7;
   localparam logic [3:0] RB_SLAVE_NACK = 4'hf;
   localparam logic [3:0] RB_ACK_STOP = 4'h1;
   localparam logic [3:0] RB_NACK_STOP = 4'h9;
   localparam logic [3:0] RB_SPI_PRE = 4'h7;
   localparam logic [3:0] RB_SPI_POST = 4'hf;
endpackage

/* rtl/gsmb_sync.sv */
/*
 * Two-flop synchroniser for a group of independent levels.
 * Assumes each bit is a slow level or a clock far below i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module gsmb_sync #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic i_clk,               // System clock
   input wire logic i_rst_n,             // Synchronised reset, low active
   input wire logic [WIDTH-1:0] i_d,     // Asynchronous levels
   output logic [WIDTH-1:0] o_q          // Levels in the clock domain
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // First stage feeds only the second; idle lines are high
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= i_d;
         sync_q <= meta_q;
      end
   end

   assign o_q = sync_q;
endmodule
`default_nettype wire

/* tb/gsmb_bridge_chk.sv */
/* Port assertions of the serial master bridge.
   Assumes pin output bits stay steady while frames run. */
`timescale 1ns/1ps
`default_nettype none
module gsmb_bridge_chk (
   input wire logic i_clk,                 // Clock
   input wire logic i_arst_n,              // Reset
   input wire logic i_host_chip_select_n,  // Host select
   input wire logic [2:0] i_aux_out_bits,  // Pin bits
   input wire logic o_host_sdo,            // Host data out
   input wire logic o_aux_pin_3,           // Pin 3 value
   input wire logic o_aux_pin_4,           // Pin 4 value
   input wire logic o_aux_pin_5,           // Pin 5 value
   input wire logic o_aux_pin_3_oe,        // Pin 3 enable
   input wire logic o_aux_pin_4_oe,        // Pin 4 enable
   input wire logic o_aux_pin_5_oe         // Pin 5 enable
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   a_drive_zero: assert property (!(o_aux_pin_3 | o_aux_pin_4 | o_aux_pin_5)) else $error("pin value high");
   a_gate_low: assert property ($stable(i_aux_out_bits)[*4] |->
      (~i_aux_out_bits & ~{o_aux_pin_5_oe, o_aux_pin_4_oe, o_aux_pin_3_oe}) == 3'h0) else $error("pin not held");
   a_idle_sdo: assert property (i_host_chip_select_n[*6] |-> o_host_sdo) else $error("sdo not idle");
   a_rst_pins: assert property ($rose(i_arst_n) && &i_aux_out_bits |->
      !(o_aux_pin_3_oe | o_aux_pin_4_oe | o_aux_pin_5_oe)[*2]) else $error("pins held at reset");
   a_clk_low_len: assert property ($rose(o_aux_pin_5_oe) |=> o_aux_pin_5_oe[*4]) else $error("short low");
   a_clk_high_len: assert property ($fell(o_aux_pin_5_oe) |=> !o_aux_pin_5_oe[*4]) else $error("short high");
   a_idle_hold: assert property ((i_host_chip_select_n && &i_aux_out_bits)[*8] |->
      !$rose(o_aux_pin_3_oe | o_aux_pin_4_oe | o_aux_pin_5_oe)) else $error("pin moved idle");
   a_spi_data_hold: assert property ($fell(o_aux_pin_5_oe) && o_aux_pin_3_oe |->
      $stable(o_aux_pin_4_oe)[*4]) else $error("data moved at sck rise");
   cover property ($fell(o_aux_pin_3_oe));
   cover property ($rose(o_aux_pin_4_oe) && !o_aux_pin_5_oe);
   cover property (!o_host_sdo);
endmodule
bind gsmb_bridge gsmb_bridge_chk gsmb_bridge_chk_inst (.i_clk, .i_arst_n, .i_host_chip_select_n,
   .i_aux_out_bits, .o_host_sdo, .o_aux_pin_3, .o_aux_pin_4, .o_aux_pin_5,
   .o_aux_pin_3_oe, .o_aux_pin_4_oe, .o_aux_pin_5_oe);
`default_nettype wire

/* tb/gsmb_slave.sv */
/* SPI slave model: pulls the data pin low per pattern bit.
   Assumes the bench resolves the open-drain pins with pull-ups. */
`timescale 1ns/1ps
`default_nettype none
module gsmb_slave (
   input wire logic i_cs,         // Select level
   input wire logic i_sck,        // Clock level
   input wire logic [7:0] i_pat,  // Byte returned each slot
   output logic o_pull = 1'b0     // High pulls data low
);
   logic [2:0] idx_q = 3'h7;
   // msb first, shift on leading (falling) edge
   always @(negedge i_sck or posedge i_cs) begin
      if (i_cs) begin
         idx_q <= 3'h7;
         o_pull <= 1'b0;
      end else begin
         o_pull <= !i_pat[idx_q];
         idx_q <= idx_q - 3'h1;
      end
   end
endmodule
`default_nettype wire

/* tb/tb.sv */
/* Bench: host frames load, run and read the store; SPI and I2C runs.
   Assumes pull-ups on all pins and a slave model on the SPI pins. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic i_clk = 1'b0, i_arst_n = 1'b0, cs_n = 1'b1, sck = 1'b1, sdi = 1'b1, ck_ok = 1'b1;
   logic sdo, oe3, oe4, oe5, pull, p3, p4, p5;
   logic [2:0] bits = 3'h7;
   logic [15:0] rchk = 16'h0;
   logic [7:0] pat = 8'h0;
   logic [63:0] rd;
   logic [23:0] d;
   int fail_count = 0, n_compared = 0, seed;
   // Open-drain pins resolved against pull-ups
   assign p3 = !oe3;
   assign p4 = !(oe4 | pull);
   assign p5 = !oe5;
   always #5 i_clk = ~i_clk;
   gsmb_bridge #(.WDOG_CYCLES(3000)) gsmb_bridge_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
      .i_host_chip_select_n(cs_n), .i_host_sck(sck), .i_host_sdi(sdi), .o_host_sdo(sdo),
      .i_data_check_ok(ck_ok), .i_read_check_code(rchk), .i_aux_out_bits(bits),
      .i_aux_pin_3(p3), .o_aux_pin_3(), .o_aux_pin_3_oe(oe3), .i_aux_pin_4(p4), .o_aux_pin_4(),
      .o_aux_pin_4_oe(oe4), .i_aux_pin_5(p5), .o_aux_pin_5(), .o_aux_pin_5_oe(oe5));
   gsmb_slave gsmb_slave_inst (.i_cs(p3), .i_sck(p5), .i_pat(pat), .o_pull(pull));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // Store after an SPI run: fixed codes, wired-and data
   function automatic logic [47:0] spi_rb(input logic [23:0] v, input logic [7:0] p);
      return {4'h7, v[23:16] & p, 8'hf7, v[15:8] & p, 8'hf7, v[7:0] & p, 4'hf};
   endfunction
   // Host frame, 160 ns clock; sdo taken late in each low phase
   task automatic frame(input logic [15:0] cmd, input int n, input logic [63:0] dat);
      logic [95:0] w;
      w = {cmd, 16'h0, dat};
      cs_n = 1'b0;
      tick(8);
      for (int k = 0; k < 32 + n; k++) begin
         sck = 1'b0;
         sdi = w[95];
         w = w << 1;
         tick(8);
         rd = {rd[62:0], sdo};
         sck = 1'b1;
         tick(8);
      end
      cs_n = 1'b1;
      tick(20);
   endtask
   task automatic wr(input logic [47:0] s, input logic ok);
      ck_ok = ok;
      frame(gsmb_pkg::CMD_LOAD_HOLDING, 64, {s, 16'h0});
      ck_ok = 1'b1;
   endtask
   task automatic rdchk(input logic [47:0] e);
      rchk = 16'($random(seed));
      frame(gsmb_pkg::CMD_READ_HOLDING, 64, 64'h0);
      chk(rd, {e, rchk});
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Cuts a hang short
   initial begin
      #1_000_000;
      fail_count++;
      end_of_test();
   end
   // Main sequence
   initial begin
      seed = 32'h8fa9d9d5;
      tick(12);
      i_arst_n = 1'b1;
      tick(6);
      rdchk(48'hffffffffffff);
      d = 24'($random(seed));
      wr({d, d ^ 24'h5a5a5a}, 1'b1);
      rdchk({d, d ^ 24'h5a5a5a});
      wr({d, d}, 1'b0);
      rdchk(48'hffffffffffff);
      for (int r = 0; r < 2; r++) begin
         d = 24'($random(seed));
         pat = 8'($random(seed));
         wr({4'h8, d[23:16], 4'h0, 4'ha, d[15:8], 4'h0, 4'h8, d[7:0], 4'h9}, 1'b1);
         frame(gsmb_pkg::CMD_RUN_TRANSFER, 72, 64'h0);
         chk({p3, p5}, 64'h3);
         rdchk(spi_rb(d, pat));
      end
      d = 24'($random(seed));
      wr({4'h6, d[23:16], 8'h80, d[15:8], 8'h01, d[7:0], 4'h8}, 1'b1);
      frame(gsmb_pkg::CMD_RUN_TRANSFER, 72, 64'h0);
      chk({p4, p5}, 64'h3);
      rdchk({4'h6, d[23:16], 8'hf7, d[15:8], 8'h01, d[7:0], 4'h8});
      wr({4'h7, d[23:16], 8'h06, d[15:8], 8'h99, d[7:0], 4'h9}, 1'b1);
      frame(gsmb_pkg::CMD_RUN_TRANSFER, 72, 64'h0);
      chk({p3, p4, p5}, 64'h7);
      rdchk({4'h7, d[23:16], 8'h06, d[15:8], 8'h97, d[7:0], 4'hf});
      bits = 3'h5;
      tick(6);
      chk(p4, 64'h0);
      bits = 3'h7;
      // select left low, held across a command
      d = 24'($random(seed));
      wr({4'h8, d[23:16], 8'h08, d[15:8], 8'h08, d[7:0], 4'h0}, 1'b1);
      frame(gsmb_pkg::CMD_RUN_TRANSFER, 72, 64'h0);
      rdchk(spi_rb(d, pat));
      chk(p3, 64'h0);
      tick(3100);
      chk({p3, p4, p5}, 64'h7);
      rdchk(48'hffffffffffff);
      end_of_test();
   end
endmodule
`default_nettype wire
